/* src/adc_cfg_pkg.sv */
// constants, encodings and register map for the converter configuration block
// Function
// (RL1) four simultaneous channels, 16-bit results
// (RL2) two-bit input selector for each channel
// (RL3) per-channel gain from 1 to 128
// (RL4) full scale equals reference over gain
// (RL5) shared test level, two fifteenths full scale
// (RL6) no results before reference has settled
// (RL7) one bit picks external or internal clock
// (RL8) clock source defaults to external pin
// (RL9) system keeps external clock running continuously
// (RL10) two-bit field picks one of three modes
// (RL11) up to 32 kSPS in high resolution; the code strobes once per 256 mclk in every mode, 781.25 kSPS at 200 MHz
// (RL12) sync pulse aligns conversion timing
// (RL13) modulator clock is half main clock
// (RL14) oscillator off at reset, divided 1/2/4
// (RL15) host enters standby before clock changes
// (RL16) selector codes: pins, ground, plus, minus
// (RL17) gain code k means gain two to k
package adc_cfg_pkg;
    localparam int NUM_CH = 4;
    localparam int RES_W = 16;
    localparam int ADDR_W = 12;
    // register byte addresses
    localparam logic [11:0] ADDR_CHAN_CFG = 12'h000;
    localparam logic [11:0] ADDR_GAIN = 12'h004;
    localparam logic [11:0] ADDR_CLOCK = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    // field positions
    localparam int SEL_W = 2;
    localparam int GAIN_W = 3;
    localparam int CLK_SEL_POS = 0;
    localparam int PWR_POS = 1;
    localparam int STANDBY_POS = 3;
    localparam int STAT_REF_POS = 0;
    localparam int STAT_SYNC_POS = 1;
    // reset values
    localparam logic [7:0] CHAN_CFG_RST = 8'h00;
    localparam logic [11:0] GAIN_RST = 12'h000;
    localparam logic CLK_SEL_RST = 1'b0;
    localparam logic STANDBY_RST = 1'b0;
    typedef enum logic [1:0] {
        SEL_PINS = 2'b00,
        SEL_GROUND = 2'b01,
        SEL_TEST_POS = 2'b10,
        SEL_TEST_NEG = 2'b11
    } input_sel_e;
    typedef enum logic [1:0] {
        PWR_HIGH_RES = 2'b00,
        PWR_LOW = 2'b01,
        PWR_VERY_LOW = 2'b10,
        PWR_RESERVED = 2'b11
    } power_mode_e;
    localparam power_mode_e PWR_RST = PWR_HIGH_RES;
    // oscillator divide ratios
    localparam logic [2:0] OSC_DIV_HR = 3'h1;
    localparam logic [2:0] OSC_DIV_LP = 3'h2;
    localparam logic [2:0] OSC_DIV_VLP = 3'h4;
    // 2/15 of positive full scale 0x7fff, and its negative
    localparam logic [15:0] TEST_CODE_POS = 16'h1111;
    localparam logic [15:0] TEST_CODE_NEG = 16'heeef;
    localparam logic [15:0] GROUND_CODE = 16'h0000;
    // timing
    localparam int MCLK_MHZ = 200;
    localparam int REF_SETTLE_NS = 5000;
    localparam int REF_SETTLE_CYC = (REF_SETTLE_NS * MCLK_MHZ + 999) / 1000;
    localparam int REF_CNT_W = 11;
    localparam int MOD_DIV = 2;
    localparam int OSR_HR = 128;
    localparam int OSR_CNT_W = 7;
endpackage

/* src/adc_cfg_top.sv */
// channel, gain, clock-source and power-mode configuration with apb registers
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module adc_cfg_top (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic [adc_cfg_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sync pin, asynchronous, active low
    input wire logic sync_n,
    // decimator results, same clock
    input wire logic conv_valid,
    input wire logic [63:0] conv_data,
    // timing enables
    output logic mod_clk_en,
    output logic sample_strobe,
    // analog controls
    output logic [7:0] channel_input_select,
    output logic [11:0] channel_gain_field,
    output logic clk_src_internal,
    output logic osc_enable,
    output logic [2:0] osc_div_ratio,
    output logic [1:0] power_level_select,
    output logic standby,
    // gated results
    output logic res_valid,
    output logic [63:0] res_data
);
    import adc_cfg_pkg::*;

    // register state
    logic [7:0] chan_cfg_q;
    logic [11:0] gain_q;
    logic clk_sel_q;
    power_mode_e pwr_q;
    logic standby_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // apb decode
    wire setup_ph = psel && !penable;
    wire access_ph = psel && penable;
    wire hit_chan = (paddr == ADDR_CHAN_CFG);
    wire hit_gain = (paddr == ADDR_GAIN);
    wire hit_clock = (paddr == ADDR_CLOCK);
    wire hit_status = (paddr == ADDR_STATUS);
    wire mapped = hit_chan || hit_gain || hit_clock || hit_status;
    wire wr_en = access_ph && pwrite && mapped;
    wire [31:0] byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // current register words
    wire [31:0] chan_word = {24'h000000, chan_cfg_q};
    wire [31:0] gain_word = {20'h00000, gain_q};
    wire [31:0] clock_word = {28'h0000000, standby_q, pwr_q, clk_sel_q};
    logic ref_ready_q;
    logic sync_hold;
    wire [31:0] status_word = {30'h00000000, sync_hold, ref_ready_q};

    // merged write data
    wire [31:0] chan_new = (pwdata & byte_mask) | (chan_word & ~byte_mask);
    wire [31:0] gain_new = (pwdata & byte_mask) | (gain_word & ~byte_mask);
    wire [31:0] clock_new = (pwdata & byte_mask) | (clock_word & ~byte_mask);
    wire [1:0] pwr_new = clock_new[PWR_POS+1:PWR_POS];
    // reserved power code keeps the previous mode
    wire pwr_ok = (pwr_new != PWR_RESERVED); // RL10

    wire [31:0] rd_mux = hit_chan ? chan_word :
                         hit_gain ? gain_word :
                         hit_clock ? clock_word :
                         hit_status ? status_word : 32'h00000000;

    // read data captured in setup, zero wait states
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (setup_ph) begin
            prdata_q <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= !mapped;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = access_ph && pslverr_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chan_cfg_q <= CHAN_CFG_RST;
            gain_q <= GAIN_RST;
            clk_sel_q <= CLK_SEL_RST; // RL8
            pwr_q <= PWR_RST;
            standby_q <= STANDBY_RST;
        end else if (wr_en) begin
            if (hit_chan) begin
                chan_cfg_q <= chan_new[7:0]; // RL2
            end
            if (hit_gain) begin
                gain_q <= gain_new[11:0]; // RL3
            end
            if (hit_clock) begin
                clk_sel_q <= clock_new[CLK_SEL_POS]; // RL7
                standby_q <= clock_new[STANDBY_POS];
                if (pwr_ok) begin
                    pwr_q <= power_mode_e'(pwr_new);
                end
            end
        end
    end

    // clock source and oscillator divider
    assign clk_src_internal = clk_sel_q; // RL7
    assign osc_enable = clk_sel_q; // RL14
    // no glitch-free switcher: host must be in standby when changing these
    assign osc_div_ratio = (pwr_q == PWR_LOW) ? OSC_DIV_LP :
                           (pwr_q == PWR_VERY_LOW) ? OSC_DIV_VLP : OSC_DIV_HR; // RL14
    assign power_level_select = pwr_q; // RL10
    assign standby = standby_q;
    assign channel_input_select = chan_cfg_q;
    // analog pga takes the exponent, full scale is reference over 2^k
    assign channel_gain_field = gain_q; // RL4 RL17

    // sync pin synchroniser
    logic sync_s1_q;
    logic sync_s2_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_s1_q <= 1'b1;
            sync_s2_q <= 1'b1;
        end else begin
            sync_s1_q <= sync_n;
            sync_s2_q <= sync_s1_q;
        end
    end
    // modulator phase and osr counter held while the pin is low, both restart on release
    assign sync_hold = !sync_s2_q; // RL12

    // modulator enable at half the main clock
    logic mod_ph_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mod_ph_q <= 1'b0;
        end else if (sync_hold) begin
            mod_ph_q <= 1'b0;
        end else begin
            mod_ph_q <= !mod_ph_q; // RL13
        end
    end
    assign mod_clk_en = mod_ph_q;

    // one sample instant shared by all channels, osr 128 in every mode
    logic [OSR_CNT_W-1:0] osr_cnt_q;
    logic strobe_q;
    wire osr_wrap = mod_ph_q && (osr_cnt_q == OSR_CNT_W'(OSR_HR - 1));
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            osr_cnt_q <= '0;
            strobe_q <= 1'b0;
        end else if (sync_hold) begin
            osr_cnt_q <= '0;
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= osr_wrap; // RL1 RL11
            if (mod_ph_q) begin
                osr_cnt_q <= osr_cnt_q + 1'b1;
            end
        end
    end
    assign sample_strobe = strobe_q;

    // reference settling gate
    logic [REF_CNT_W-1:0] ref_cnt_q;
    wire ref_last = (ref_cnt_q == REF_CNT_W'(REF_SETTLE_CYC - 1));
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_q <= '0;
            ref_ready_q <= 1'b0;
        end else if (!ref_ready_q) begin
            ref_cnt_q <= ref_cnt_q + 1'b1;
            ref_ready_q <= ref_last; // RL6
        end
    end

    // per-channel result selection
    wire take = conv_valid && ref_ready_q; // RL6
    logic [63:0] sel_data;
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            wire [1:0] sel = chan_cfg_q[ch*SEL_W +: SEL_W];
            wire [15:0] raw = conv_data[ch*RES_W +: RES_W];
            // test code is gain independent
            assign sel_data[ch*RES_W +: RES_W] =
                (sel == SEL_GROUND) ? GROUND_CODE :
                (sel == SEL_TEST_POS) ? TEST_CODE_POS :
                (sel == SEL_TEST_NEG) ? TEST_CODE_NEG : raw; // RL5 RL16
        end
    endgenerate

    logic res_valid_q;
    logic [63:0] res_data_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            res_valid_q <= 1'b0;
            res_data_q <= 64'h0000000000000000;
        end else begin
            res_valid_q <= take; // RL6
            if (take) begin
                res_data_q <= sel_data; // RL1
            end
        end
    end
    assign res_valid = res_valid_q;
    assign res_data = res_data_q;

    // assertion helpers
    logic first_q;
    logic [7:0] sel_past_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            first_q <= 1'b1;
            sel_past_q <= 8'h00;
        end else begin
            first_q <= 1'b0;
            sel_past_q <= chan_cfg_q;
        end
    end

    property p_clk_default;
        @(posedge mclk) disable iff (!rst_n)
        first_q |-> (!clk_src_internal && !osc_enable);
    endproperty
    a_clk_default: assert property (p_clk_default) else $error("clock source not external after reset"); // RL8

    property p_no_early_data;
        @(posedge mclk) disable iff (!rst_n)
        res_valid |-> $past(ref_ready_q);
    endproperty
    a_no_early_data: assert property (p_no_early_data) else $error("result before reference settled"); // RL6

    property p_ref_time;
        @(posedge mclk) disable iff (!rst_n)
        $rose(ref_ready_q) |-> $past(ref_cnt_q) == REF_CNT_W'(REF_SETTLE_CYC - 1);
    endproperty
    a_ref_time: assert property (p_ref_time) else $error("reference settle count wrong"); // RL6

    property p_mod_half;
        @(posedge mclk) disable iff (!rst_n)
        (!sync_hold && mod_clk_en) ##1 !sync_hold |-> !mod_clk_en ##1 (sync_hold || mod_clk_en);
    endproperty
    a_mod_half: assert property (p_mod_half) else $error("modulator enable not half rate"); // RL13

    property p_osc_div;
        @(posedge mclk) disable iff (!rst_n)
        (power_level_select == PWR_VERY_LOW) |-> osc_div_ratio == OSC_DIV_VLP;
    endproperty
    a_osc_div: assert property (p_osc_div) else $error("oscillator divider mismatch"); // RL14

    property p_test_code;
        @(posedge mclk) disable iff (!rst_n)
        res_valid && sel_past_q[5:4] == SEL_TEST_POS |-> res_data[47:32] == TEST_CODE_POS;
    endproperty
    a_test_code: assert property (p_test_code) else $error("positive test code wrong"); // RL5

    property p_ground_code;
        @(posedge mclk) disable iff (!rst_n)
        res_valid && sel_past_q[3:2] == SEL_GROUND |-> res_data[31:16] == GROUND_CODE;
    endproperty
    a_ground_code: assert property (p_ground_code) else $error("ground code not zero"); // RL16

    property p_test_neg;
        @(posedge mclk) disable iff (!rst_n)
        res_valid && sel_past_q[7:6] == SEL_TEST_NEG |-> res_data[63:48] == TEST_CODE_NEG;
    endproperty
    a_test_neg: assert property (p_test_neg) else $error("negative test code wrong"); // RL5 RL16

    property p_pins_pass;
        @(posedge mclk) disable iff (!rst_n)
        res_valid && sel_past_q[1:0] == SEL_PINS |-> res_data[15:0] == $past(conv_data[15:0]);
    endproperty
    a_pins_pass: assert property (p_pins_pass) else $error("pin data changed"); // RL2 RL16

    property p_take_next;
        @(posedge mclk) disable iff (!rst_n)
        conv_valid && ref_ready_q |=> res_valid;
    endproperty
    a_take_next: assert property (p_take_next) else $error("result dropped"); // RL6

    property p_ref_hold;
        @(posedge mclk) disable iff (!rst_n)
        ref_ready_q |=> ref_ready_q;
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("reference ready fell"); // RL6

    property p_osc_div_lp;
        @(posedge mclk) disable iff (!rst_n)
        (power_level_select == PWR_LOW) |-> osc_div_ratio == OSC_DIV_LP;
    endproperty
    a_osc_div_lp: assert property (p_osc_div_lp) else $error("low power divider wrong"); // RL14

    property p_osc_div_hr;
        @(posedge mclk) disable iff (!rst_n)
        (power_level_select == PWR_HIGH_RES) |-> osc_div_ratio == OSC_DIV_HR;
    endproperty
    a_osc_div_hr: assert property (p_osc_div_hr) else $error("high res divider wrong"); // RL14

    property p_gain_write;
        @(posedge mclk) disable iff (!rst_n)
        wr_en && hit_gain && pstrb == 4'hf |=> channel_gain_field == $past(pwdata[11:0]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain write lost"); // RL3 RL17

    property p_strobe_gap;
        @(posedge mclk) disable iff (!rst_n)
        sample_strobe |=> (!sample_strobe)[*8];
    endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("sample strobes too close"); // RL11

    property p_sync_hold;
        @(posedge mclk) disable iff (!rst_n)
        sync_hold |=> !mod_clk_en && !sample_strobe;
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("timing ran during sync"); // RL12

    property p_pwr_reserved;
        @(posedge mclk) disable iff (!rst_n)
        wr_en && hit_clock && !pwr_ok |=> $stable(power_level_select);
    endproperty
    a_pwr_reserved: assert property (p_pwr_reserved) else $error("reserved power code taken"); // RL10

    property p_clk_write;
        @(posedge mclk) disable iff (!rst_n)
        wr_en && hit_clock |=> clk_src_internal == $past(clock_new[CLK_SEL_POS]);
    endproperty
    a_clk_write: assert property (p_clk_write) else $error("clock select write lost"); // RL7

    c_internal_clock: cover property (@(posedge mclk) disable iff (!rst_n) $rose(osc_enable));
    c_result: cover property (@(posedge mclk) disable iff (!rst_n) res_valid);
    c_sync: cover property (@(posedge mclk) disable iff (!rst_n) $fell(sync_hold));
    c_unmapped: cover property (@(posedge mclk) disable iff (!rst_n) pslverr);
    c_reserved_power: cover property (@(posedge mclk) disable iff (!rst_n)
        wr_en && hit_clock && !pwr_ok);
endmodule

/* tb/conv_source.sv */
// decimator stand-in: one result word per request, scrambled data between
`timescale 1ns/1ps
module conv_source (
    // clock
    input wire logic mclk,
    // request from bench
    input wire logic fire,
    input wire logic [63:0] sample,
    // result side
    output logic conv_valid,
    output logic [63:0] conv_data
);
    initial begin
        conv_valid = 1'b0;
        conv_data = 64'h0;
    end
    // four 16-bit lanes; stale data inverted so a late capture shows up
    always @(posedge mclk) begin
        conv_valid <= fire;
        conv_data <= fire ? sample : ~conv_data;
    end
endmodule

/* tb/tb_adc_channel_and_clock_config.sv */
// self-checking bench for the converter configuration block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_adc_channel_and_clock_config;
    import adc_cfg_pkg::*;
    logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, sync_n = 1, fire = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, er, conv_valid, mod_clk_en, sample_strobe;
    logic [63:0] sample = 64'h0, conv_data, res_data;
    logic [7:0] channel_input_select;
    logic [11:0] channel_gain_field;
    logic clk_src_internal, osc_enable, standby, res_valid;
    logic [2:0] osc_div_ratio;
    logic [1:0] power_level_select;
    int num_errors = 0, compares = 0;
    always #2.5 mclk = ~mclk;
    adc_cfg_top u_dut (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_n(sync_n),
        .conv_valid(conv_valid), .conv_data(conv_data), .mod_clk_en(mod_clk_en),
        .sample_strobe(sample_strobe), .channel_input_select(channel_input_select),
        .channel_gain_field(channel_gain_field), .clk_src_internal(clk_src_internal),
        .osc_enable(osc_enable), .osc_div_ratio(osc_div_ratio),
        .power_level_select(power_level_select), .standby(standby),
        .res_valid(res_valid), .res_data(res_data));
    conv_source u_src (.mclk(mclk), .fire(fire), .sample(sample),
        .conv_valid(conv_valid), .conv_data(conv_data));
    task automatic results;
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one apb transfer; returns once outputs of the access edge have settled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            num_errors++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pstrb <= 4'hf;
        @(negedge mclk);
    endtask
    task automatic t_reset;
        logic prev;
        apb(0, ADDR_CLOCK, 0);
        `CHK("clock_reg", 32'h0, rd)
        `CHK("clk_src", 1'b0, clk_src_internal)
        `CHK("osc_en", 1'b0, osc_enable)
        apb(0, ADDR_STATUS, 0);
        `CHK("ref_early", 1'b0, rd[STAT_REF_POS])
        apb(0, ADDR_CHAN_CFG, 0);
        `CHK("chan_rst", 32'h0, rd)
        prev = mod_clk_en;
        @(negedge mclk);
        `CHK("mod_alt", ~prev, mod_clk_en)
        prev = mod_clk_en;
        @(negedge mclk);
        `CHK("mod_alt2", ~prev, mod_clk_en)
        @(posedge mclk) fire <= 1'b1;
        @(posedge mclk) fire <= 1'b0;
        repeat (4) @(negedge mclk) `CHK("res_early", 1'b0, res_valid)
    endtask
    task automatic t_gain;
        apb(1, ADDR_GAIN, 32'h0000_0fac);
        `CHK("gain_out", 12'hfac, channel_gain_field)
        @(posedge mclk) pstrb <= 4'h1;
        apb(1, ADDR_GAIN, 32'h0000_0321);
        `CHK("gain_lane", 12'hf21, channel_gain_field)
        apb(0, ADDR_GAIN, 0);
        `CHK("gain_rd", 32'h0000_0f21, rd)
        apb(1, 12'h010, 32'hffff_ffff);
        `CHK("unmap_err", 1'b1, er)
        `CHK("unmap_rd", 32'h0, rd)
    endtask
    task automatic t_clock;
        // standby first: the clock switch has no glitch guard
        apb(1, ADDR_CLOCK, 32'h0000_0008);
        `CHK("stby_in", 1'b1, standby)
        for (int i = 0; i < 3; i++) begin
            apb(1, ADDR_CLOCK, 32'h9 | (i << 1));
            `CHK("pwr", 2'(i), power_level_select)
            `CHK("div", 3'h1 << i, osc_div_ratio)
            `CHK("clk_int", 1'b1, clk_src_internal)
            `CHK("osc_on", 1'b1, osc_enable)
        end
        // reserved power code must leave the mode alone
        apb(1, ADDR_CLOCK, 32'h0000_000e);
        `CHK("pwr_keep", 2'b10, power_level_select)
        `CHK("stby", 1'b1, standby)
        `CHK("clk_ext", 1'b0, clk_src_internal)
        apb(0, ADDR_CLOCK, 0);
        `CHK("clock_rd", 32'h0000_000c, rd)
        apb(1, ADDR_CLOCK, 32'h0000_0008);
        `CHK("pwr_hr", 2'b00, power_level_select)
        apb(1, ADDR_CLOCK, 32'h0);
    endtask
    task automatic t_results;
        int n;
        for (n = 0; n < 600; n++) begin
            apb(0, ADDR_STATUS, 0);
            if (rd[STAT_REF_POS] === 1'b1) break;
        end
        `CHK("ref_ready", 1'b1, rd[STAT_REF_POS])
        // ch0 pins, ch1 ground, ch2 plus test, ch3 minus test
        apb(1, ADDR_CHAN_CFG, 32'h0000_00e4);
        `CHK("sel_out", 8'he4, channel_input_select)
        for (int g = 0; g < 2; g++) begin
            apb(1, ADDR_GAIN, g ? 32'h0000_0fff : 32'h0);
            @(posedge mclk);
            sample <= 64'h5a5a_3c3c_7e7e_1234 + g;
            fire <= 1'b1;
            @(posedge mclk) fire <= 1'b0;
            for (n = 0; n < 10; n++) begin
                @(negedge mclk);
                if (res_valid === 1'b1) break;
            end
            `CHK("res_valid", 1'b1, res_valid)
            `CHK("res_data", {TEST_CODE_NEG, TEST_CODE_POS, GROUND_CODE, 16'(16'h1234 + g)},
                res_data)
            @(negedge mclk);
            `CHK("res_pulse", 1'b0, res_valid)
        end
    endtask
    task automatic t_sync;
        int n;
        @(posedge mclk) sync_n <= 1'b0;
        repeat (4) @(posedge mclk);
        repeat (3) @(negedge mclk) `CHK("sync_mod", 1'b0, mod_clk_en)
        apb(0, ADDR_STATUS, 0);
        `CHK("sync_stat", 1'b1, rd[STAT_SYNC_POS])
        @(posedge mclk) sync_n <= 1'b1;
        for (n = 0; n < 400; n++) begin
            @(negedge mclk);
            if (sample_strobe === 1'b1) break;
        end
        // first strobe 256 mclk after release, within sync pipeline slack
        `CHK("strobe_dly", 1'b1, (n >= 250 && n <= 262))
        for (n = 0; n < 300; n++) begin
            @(negedge mclk);
            if (sample_strobe === 1'b1) break;
        end
        `CHK("strobe_per", 255, n)
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_gain();
        t_clock();
        t_results();
        t_sync();
        results();
    end
    initial begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        results();
    end
endmodule
